// File: hdl/adcc_pkg.sv
package adcc_pkg;

	// Byte addresses of the register words.
	localparam logic [7:0] ADDR_CTRL_MAIN  = 8'h00;
	localparam logic [7:0] ADDR_IN_CLK_SEL = 8'h04;
	localparam logic [7:0] ADDR_REF_AMP    = 8'h08;
	localparam logic [7:0] ADDR_BANDGAP    = 8'h0C;
	localparam logic [7:0] ADDR_RES_HIGH   = 8'h10;
	localparam logic [7:0] ADDR_RES_LOW    = 8'h14;

	// Field positions in adc_control_main.
	localparam int BIT_START   = 7;
	localparam int BIT_BUSY    = 6;
	localparam int BIT_ENABLE  = 5;
	localparam int BIT_FORMAT  = 4;
	localparam int LSB_CHANNEL = 0;
	// Field positions in adc_input_clock_select.
	localparam int LSB_SOURCE  = 4;
	localparam int LSB_CLKDIV  = 0;
	// Field positions in adc_reference_amp_control.
	localparam int BIT_AMP_EN  = 7;
	localparam int BIT_AMP_IN  = 4;
	localparam int LSB_VREF    = 2;
	localparam int LSB_GAIN    = 0;
	// Field position in bandgap_control.
	localparam int BIT_BG_EN   = 0;

	// Values after reset.
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [3:0] RST_FLD4 = 4'h0;
	localparam logic [2:0] RST_FLD3 = 3'h0;
	localparam logic [1:0] RST_FLD2 = 2'h0;

	// Converter clock periods per conversion.
	localparam int CONV_CLOCKS = 16;
	// Width of the converter clock prescaler, enough for a divide by 128.
	localparam int DIV_W       = 7;
	// Number of external channel slots, slot 2 is reserved.
	localparam int NUM_CHAN    = 5;
	localparam int RES_W       = 12;

	typedef enum logic {
		ADCC_IDLE,
		ADCC_CONV
	} adcc_state_t;

endpackage : adcc_pkg

// File: hdl/adcc_div_if.sv
`timescale 1ns/100ps
interface adcc_div_if;
	logic [2:0] div_sel;
	logic       run;
	logic       tick;

	modport ctl (output div_sel, output run, input tick);
	modport div (input div_sel, input run, output tick);
endinterface : adcc_div_if

// File: hdl/adcc_clk_div.sv
`timescale 1ns/100ps
module adcc_clk_div #(
	parameter int W = adcc_pkg::DIV_W
) (
	input  wire logic pclk,
	input  wire logic presetn,
	adcc_div_if.div   dif
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} adcc_div_st_t;

	adcc_div_st_t s_q;
	adcc_div_st_t s_d;
	logic [W-1:0] mask;

	// A tick comes every 2^div_sel clocks; sel zero ticks every clock.
	always_comb begin
		mask = W'((1 << dif.div_sel) - 1);
		s_d  = s_q;
		if (!dif.run) begin
			s_d.cnt = '0;
		end else begin
			s_d.cnt = s_q.cnt + W'(1);
		end
	end

	assign dif.tick = dif.run && ((s_q.cnt & mask) == mask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : adcc_clk_div

// File: hdl/adcc_top.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
// How it works
// - Start on start bit written high then low.
// - Busy set at start, cleared at completion.
// - Disabled converter off; result bytes untouched.
// - Format bit picks left or right alignment.
// - Unused result bits read as zero.
// - Channel code 0, 1, 3 or 4 picks one external input; other codes pick none.
// - Source field picks external or internal signal.
// - Internal source disconnects every external channel.
// - Converter clock is system clock over 2^n.
// - Unimplemented bits read as zero.
// - Bandgap amplifier input disconnects external pin.
// - Bandgap enable bit powers reference circuit.
// - Reference select; internal choice disconnects pin.
// - Gain field drives amplifier gain select.
// - Converter input pin drops function and pull-high.
// - Completion pulses the interrupt request.
module adcc_top #(
	parameter int CONV_CLOCKS = adcc_pkg::CONV_CLOCKS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [11:0] adc_sample,
	input  wire logic [4:0]  pin_adc_select,
	output logic             converter_enable,
	output logic             conv_start_pulse,
	output logic             conv_busy_flag,
	output logic             conv_done_pulse,
	output logic      [4:0]  external_analog_channel,
	output logic             ext_input_off,
	output logic      [3:0]  input_source_select,
	output logic             conv_clock_tick,
	output logic             ref_amp_enable,
	output logic             ref_amp_input_select,
	output logic             ext_amp_input_pin_off,
	output logic      [1:0]  reference_select,
	output logic             ext_ref_pin_off,
	output logic      [1:0]  ref_amp_gain_select,
	output logic             bandgap_enable,
	output logic      [4:0]  pin_release
);
	localparam int CW = $clog2(CONV_CLOCKS + 1);
	localparam logic [CW-1:0] LAST = CW'(CONV_CLOCKS - 1);

	typedef struct packed {
		logic                start;
		logic                enable;
		logic                fmt;
		logic [3:0]          chan;
		logic [3:0]          src;
		logic [2:0]          clkdiv;
		logic                amp_en;
		logic                amp_in;
		logic [1:0]          vref;
		logic [1:0]          gain;
		logic                bg_en;
		logic [7:0]          res_hi;
		logic [7:0]          res_lo;
		adcc_pkg::adcc_state_t st;
		logic [CW-1:0]       cnt;
		logic                start_p;
		logic                done_p;
		logic                tick;
		logic [4:0]          ext_conn;
		logic                ext_off;
		logic [4:0]          pin_rel;
		logic                rdy;
		logic                err;
		logic                ref_off;
		logic [31:0]         rdata;
	} adcc_st_t;

	adcc_st_t s_q;
	adcc_st_t s_d;

	adcc_div_if dif ();

	adcc_clk_div #(
		.W (adcc_pkg::DIV_W)
	) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.dif     (dif)
	);

	// The prescaler only runs while a conversion is under way, which
	// keeps the tick phase fixed relative to the start.
	assign dif.div_sel = s_q.clkdiv;
	assign dif.run     = (s_q.st == adcc_pkg::ADCC_CONV);

	logic       setup;
	logic       wr;
	logic       mapped;
	logic       is_ext;
	logic [7:0] wb;
	logic [7:0] rd8;

	always_comb begin
		s_d    = s_q;
		setup  = psel && !penable;
		wr     = psel && penable && s_q.rdy && pwrite && pstrb[0];
		wb     = pwdata[7:0];
		mapped = 1'b1;
		rd8    = 8'h00;
		s_d.start_p = 1'b0;
		s_d.done_p  = 1'b0;

		// Register writes take effect in the completing access cycle.
		if (wr) begin
			case (paddr)
				adcc_pkg::ADDR_CTRL_MAIN: begin
					s_d.start  = wb[adcc_pkg::BIT_START];
					s_d.enable = wb[adcc_pkg::BIT_ENABLE];
					s_d.fmt    = wb[adcc_pkg::BIT_FORMAT];
					s_d.chan   = wb[adcc_pkg::LSB_CHANNEL +: 4];
				end
				adcc_pkg::ADDR_IN_CLK_SEL: begin
					s_d.src    = wb[adcc_pkg::LSB_SOURCE +: 4];
					s_d.clkdiv = wb[adcc_pkg::LSB_CLKDIV +: 3];
				end
				adcc_pkg::ADDR_REF_AMP: begin
					s_d.amp_en = wb[adcc_pkg::BIT_AMP_EN];
					s_d.amp_in = wb[adcc_pkg::BIT_AMP_IN];
					s_d.vref   = wb[adcc_pkg::LSB_VREF +: 2];
					s_d.gain   = wb[adcc_pkg::LSB_GAIN +: 2];
				end
				adcc_pkg::ADDR_BANDGAP: begin
					s_d.bg_en = wb[adcc_pkg::BIT_BG_EN];
				end
				default: begin
				end
			endcase
		end

		s_d.tick = dif.tick;
		case (s_q.st)
			adcc_pkg::ADCC_IDLE: begin
				s_d.cnt = '0;
				if (s_q.start && !s_d.start && s_q.enable) begin
					s_d.st      = adcc_pkg::ADCC_CONV;
					s_d.start_p = 1'b1;
				end
			end
			adcc_pkg::ADCC_CONV: begin
				if (!s_d.enable) begin
					s_d.st = adcc_pkg::ADCC_IDLE;
				end else if (dif.tick) begin
					s_d.cnt = s_q.cnt + CW'(1);
					if (s_q.cnt == LAST) begin
						s_d.st = adcc_pkg::ADCC_IDLE;
						s_d.done_p = 1'b1;
						if (s_d.fmt) begin
							s_d.res_hi = {4'h0, adc_sample[11:8]};
							s_d.res_lo = adc_sample[7:0];
						end else begin
							s_d.res_hi = adc_sample[11:4];
							s_d.res_lo = {adc_sample[3:0], 4'h0};
						end
					end
				end
			end
			default: begin
				s_d.st = adcc_pkg::ADCC_IDLE;
			end
		endcase

		is_ext = (s_d.src[3:2] == 2'b11) ||
			(!s_d.src[3] && (s_d.src[1:0] == 2'b00));
		s_d.ext_off  = !is_ext;
		s_d.ext_conn = 5'h00;
		if (is_ext && s_d.enable && (s_d.chan < 4'(adcc_pkg::NUM_CHAN)) &&
			(s_d.chan != 4'h2)) begin
			s_d.ext_conn = 5'(5'h01 << s_d.chan);
		end
		s_d.pin_rel = pin_adc_select;
		// pin used only for code 01
		s_d.ref_off = (s_d.vref != 2'b01);

		// Read data and error are captured in setup, so the access
		// phase always completes on its first cycle.
		case (paddr)
			adcc_pkg::ADDR_CTRL_MAIN: begin
				rd8 = {s_q.start, (s_q.st == adcc_pkg::ADCC_CONV),
					s_q.enable, s_q.fmt, s_q.chan};
			end
			adcc_pkg::ADDR_IN_CLK_SEL: begin
				rd8 = {s_q.src, 1'b0, s_q.clkdiv};
			end
			adcc_pkg::ADDR_REF_AMP: begin
				rd8 = {s_q.amp_en, 2'b00, s_q.amp_in, s_q.vref, s_q.gain};
			end
			adcc_pkg::ADDR_BANDGAP: begin
				rd8 = {7'h00, s_q.bg_en};
			end
			adcc_pkg::ADDR_RES_HIGH: begin
				rd8 = s_q.res_hi;
			end
			adcc_pkg::ADDR_RES_LOW: begin
				rd8 = s_q.res_lo;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		s_d.rdy   = setup;
		s_d.err   = setup && !mapped;
		s_d.rdata = setup ? {24'h000000, rd8} : 32'h00000000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q         <= '0;
			s_q.ref_off <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata  = s_q.rdata;
	assign pready  = s_q.rdy;
	assign pslverr = s_q.err;

	assign converter_enable        = s_q.enable;
	assign conv_start_pulse        = s_q.start_p;
	assign conv_busy_flag          = (s_q.st == adcc_pkg::ADCC_CONV);
	assign conv_done_pulse         = s_q.done_p;
	assign external_analog_channel = s_q.ext_conn;
	assign ext_input_off           = s_q.ext_off;
	assign input_source_select     = s_q.src;
	assign conv_clock_tick         = s_q.tick;
	assign ref_amp_enable          = s_q.amp_en;
	assign ref_amp_input_select    = s_q.amp_in;
	assign ext_amp_input_pin_off   = s_q.amp_in;
	assign reference_select        = s_q.vref;
	assign ext_ref_pin_off         = s_q.ref_off;
	assign ref_amp_gain_select     = s_q.gain;
	assign bandgap_enable          = s_q.bg_en;
	assign pin_release             = s_q.pin_rel;
endmodule : adcc_top

// File: verif/adcc_checker.sv
`timescale 1ns/100ps
module adcc_checker (
	input logic       pclk,
	input logic       presetn,
	input logic       converter_enable,
	input logic       conv_start_pulse,
	input logic       conv_busy_flag,
	input logic       conv_done_pulse,
	input logic [4:0] external_analog_channel,
	input logic       ext_input_off,
	input logic [3:0] input_source_select,
	input logic       ref_amp_input_select,
	input logic       ext_amp_input_pin_off,
	input logic [1:0] reference_select,
	input logic       ext_ref_pin_off,
	input logic [4:0] pin_adc_select,
	input logic [4:0] pin_release
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_start_busy: assert property (conv_start_pulse |-> conv_busy_flag)
		else $error("busy low at start");
	chk_start_once: assert property (conv_start_pulse |=> !conv_start_pulse)
		else $error("start pulse too long");
	chk_busy_cause: assert property ($rose(conv_busy_flag) |-> conv_start_pulse)
		else $error("busy without start");
	chk_done_end: assert property (conv_done_pulse |-> !conv_busy_flag && $past(conv_busy_flag))
		else $error("done pulse misplaced");
	chk_no_restart: assert property (conv_busy_flag && $past(conv_busy_flag) |-> !conv_start_pulse)
		else $error("restart while busy");
	chk_off_idle: assert property (!converter_enable [*3] |-> !conv_busy_flag)
		else $error("busy while disabled");
	chk_src_off: assert property (ext_input_off == (input_source_select[3:2] == 2'h2 ||
		(input_source_select[1:0] != 2'h0 && !input_source_select[3])))
		else $error("source decode wrong");
	chk_ext_cut: assert property (ext_input_off |-> external_analog_channel == 5'h00)
		else $error("channel joined to internal");
	chk_chan_hot: assert property ($onehot0(external_analog_channel) &&
		!external_analog_channel[2]) else $error("channel connect wrong");
	chk_vref_cut: assert property (ext_ref_pin_off == (reference_select != 2'h1))
		else $error("reference pin state wrong");
	chk_amp_cut: assert property (ext_amp_input_pin_off == ref_amp_input_select)
		else $error("amp input pin state wrong");
	chk_pin_free: assert property (pin_release == $past(pin_adc_select))
		else $error("pin release wrong");
	cover property (conv_done_pulse);
	cover property (conv_start_pulse);
	cover property (ext_input_off);
endmodule : adcc_checker

bind adcc_top adcc_checker u_adcc_checker (.pclk, .presetn, .converter_enable,
	.conv_start_pulse, .conv_busy_flag, .conv_done_pulse, .external_analog_channel,
	.ext_input_off, .input_source_select, .ref_amp_input_select, .ext_amp_input_pin_off,
	.reference_select, .ext_ref_pin_off, .pin_adc_select, .pin_release);

// File: verif/tb.sv
`timescale 1ns/100ps
module tb;
	localparam int CONV = 2;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, h;
	logic [3:0]  pstrb, input_source_select;
	logic [11:0] adc_sample;
	logic [4:0]  pin_adc_select, external_analog_channel, pin_release;
	logic        converter_enable, conv_start_pulse, conv_busy_flag, conv_done_pulse;
	logic        ext_input_off, conv_clock_tick, ref_amp_enable, ref_amp_input_select;
	logic        ext_amp_input_pin_off, ext_ref_pin_off, bandgap_enable;
	logic [1:0]  reference_select, ref_amp_gain_select;
	int          fails, n_tests, cyc, n, dn, tk;
	// bandgap enabled before amp picks it
	logic [7:0]  ta[4] = '{8'h04, 8'h0C, 8'h08, 8'h00};
	logic [7:0]  te[4] = '{8'hF7, 8'h01, 8'h9F, 8'h1F};
	adcc_top #(.CONV_CLOCKS(CONV)) u_adcc_top (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .adc_sample, .pin_adc_select,
		.converter_enable, .conv_start_pulse, .conv_busy_flag, .conv_done_pulse,
		.external_analog_channel, .ext_input_off, .input_source_select, .conv_clock_tick,
		.ref_amp_enable, .ref_amp_input_select, .ext_amp_input_pin_off, .reference_select,
		.ext_ref_pin_off, .ref_amp_gain_select, .bandgap_enable, .pin_release);
	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	task finish_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			finish_test();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// One APB transfer; the slave is waited for, never assumed.
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
	task run(input logic [7:0] m);
		xfer(1'h1, 8'h00, m | 8'h80);
		xfer(1'h1, 8'h00, m);
		n = 0;
		dn = 0;
		tk = 0;
		do begin
			@(negedge pclk);
			n += conv_busy_flag;
			dn += conv_done_pulse;
			tk += conv_clock_tick;
		end while (conv_busy_flag === 1'h1);
	endtask : run
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, adc_sample, pin_adc_select} = '0;
		pstrb = 4'hF;
		{fails, n_tests, cyc} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			xfer(1'h0, 8'(i * 4), 8'h00);
			chk(r, 32'h0);
		end
		for (int i = 0; i < 4; i++) begin
			xfer(1'h1, ta[i], (i == 3) ? 8'h5F : 8'hFF);
			xfer(1'h0, ta[i], 8'h00);
			chk(r, te[i]);
		end
		xfer(1'h1, 8'h10, 8'hFF);
		xfer(1'h0, 8'h10, 8'h00);
		chk(r, 32'h0);
		xfer(1'h0, 8'h18, 8'h00);
		chk({err, r[7:0]}, 32'h100);
		xfer(1'h1, 8'h04, 8'h00);
		for (int c = 0; c < 16; c++) begin
			xfer(1'h1, 8'h00, 8'(8'h20 | c));
			@(negedge pclk);
			chk(external_analog_channel, (c < 5 && c != 2) ? 32'(1 << c) : 32'h0);
		end
		xfer(1'h1, 8'h00, 8'h21);
		for (int s = 0; s < 16; s++) begin
			xfer(1'h1, 8'h04, 8'(s << 4));
			@(negedge pclk);
			h = (s[3:2] == 2'h2 || (s[1:0] != 2'h0 && !s[3]));
			chk(ext_input_off, h);
			chk(input_source_select, s);
			chk(external_analog_channel, h ? 32'h0 : 32'h2);
		end
		@(posedge pclk);
		pin_adc_select <= 5'h15;
		repeat (2) @(negedge pclk);
		chk(pin_release, 32'h15);
		for (int i = 0; i < 16; i++) begin
			xfer(1'h1, 8'h08, {i[3] | i[0], 2'h0, i[1], i[3:2], i[1:0]});
			@(negedge pclk);
			chk({ref_amp_enable, ext_amp_input_pin_off, reference_select, ext_ref_pin_off,
				ref_amp_gain_select}, {i[3] | i[0], i[1], i[3:2], i[3:2] != 2'h1, i[1:0]});
			chk(ref_amp_input_select, i[1]);
		end
		for (int b = 1; b >= 0; b--) begin
			xfer(1'h1, 8'h0C, 8'(b));
			@(negedge pclk);
			chk(bandgap_enable, b);
		end
		for (int d = 0; d < 8; d++) begin
			xfer(1'h1, 8'h04, 8'(d));
			adc_sample <= 12'h5A3 + 12'(d * 273);
			run({3'h1, d[0], 4'h0});
			chk(n, CONV << d);
			chk(tk, CONV);
			chk(dn, 32'h1);
			xfer(1'h0, 8'h10, 8'h00);
			chk(r, d[0] ? adc_sample[11:8] : adc_sample[11:4]);
			xfer(1'h0, 8'h14, 8'h00);
			chk(r, d[0] ? adc_sample[7:0] : {adc_sample[3:0], 4'h0});
		end
		xfer(1'h1, 8'h04, 8'h04);
		xfer(1'h1, 8'h00, 8'hA0);
		xfer(1'h1, 8'h00, 8'h20);
		run(8'h20);
		n = 0;
		repeat (8) begin
			@(negedge pclk);
			n += conv_busy_flag;
		end
		chk(n, 32'h0);
		chk(dn, 32'h1);
		xfer(1'h0, 8'h10, 8'h00);
		h = r;
		adc_sample <= ~adc_sample;
		xfer(1'h1, 8'h00, 8'hA0);
		xfer(1'h1, 8'h00, 8'h20);
		xfer(1'h1, 8'h00, 8'h00);
		repeat (3) @(negedge pclk);
		chk(conv_busy_flag, 32'h0);
		chk(converter_enable, 32'h0);
		// Long enough for an unaborted conversion to have stored a result.
		repeat (40) @(negedge pclk);
		xfer(1'h0, 8'h10, 8'h00);
		chk(r, h);
		xfer(1'h1, 8'h00, 8'h80);
		xfer(1'h1, 8'h00, 8'h00);
		@(negedge pclk);
		chk(conv_busy_flag, 32'h0);
		finish_test();
	end
endmodule : tb
